// ==== design/bci_issue_ctrl.sv ====
`timescale 1ns/1ps
module bci_issue_ctrl #(
	parameter int CP_MIN     = bci_pkg::CP_MIN_CYCLES,
	parameter int CP_ALT_MIN = bci_pkg::CP_ALT_MIN_CYCLES
) (
	input  wire logic                sys_clk,
	input  wire logic                reset,
	input  wire bci_pkg::bci_instr_s slot0,
	input  wire bci_pkg::bci_instr_s slot1,
	input  wire logic                cond_pass_ex3,
	input  wire logic [31:0]         aux_ctrl_word,
	input  wire logic                cp_ack,
	output logic                     issue0,
	output logic                     issue1,
	output logic                     br_resolve,
	output logic                     br_mispredict,
	output logic [31:0]              br_new_pc,
	output logic                     lr_wr_en,
	output logic [31:0]              lr_wr_data,
	output logic                     cp_req,
	output bci_pkg::bci_unit_e       cp_unit,
	output logic                     cp_alt_timing,
	output logic                     cp_busy,
	output logic                     cp_done,
	output logic                     flush_active
);
	// ==========================================================
	// helpers
	function automatic logic is_branch(input bci_pkg::bci_instr_s i);
		return i.valid && (i.kind == bci_pkg::BCI_K_COND_BR || i.kind == bci_pkg::BCI_K_LINK_BR
			|| i.kind == bci_pkg::BCI_K_EXCH_BR || i.dst_pc);
	endfunction

	function automatic logic hazard(input bci_pkg::bci_instr_s i);
		logic [2:0] need;
		need = (i.kind == bci_pkg::BCI_K_EXCH_BR) ? bci_pkg::STG_EX_TWO : i.src_need;
		// the pc is predicted and always at hand, so it never stalls
		return i.src_reg != bci_pkg::PC_REG && i.src_avail > need;
	endfunction

	function automatic logic [3:0] exec_cycles(input bci_pkg::bci_instr_s i);
		if (i.kind == bci_pkg::BCI_K_LOAD && i.dst_pc)
			return i.base_cycles + 4'h1;
		else if (i.kind == bci_pkg::BCI_K_COND_BR || i.kind == bci_pkg::BCI_K_LINK_BR
			|| i.kind == bci_pkg::BCI_K_EXCH_BR || i.kind == bci_pkg::BCI_K_CP)
			return 4'h1;
		else
			return i.base_cycles;
	endfunction

	function automatic logic nonpipe(input bci_pkg::bci_instr_s i);
		return i.kind == bci_pkg::BCI_K_CP && bci_pkg::cp_unit(i) != bci_pkg::BCI_U_NONE;
	endfunction

	bci_cp_if              cp_bus ();
	bci_pkg::bci_tok_s     st_r [1:4];
	bci_pkg::bci_tok_s     tok_new;
	bci_pkg::bci_instr_s   br_src;
	logic [3:0]            multi_left_r;
	logic [4:0]            flush_cnt_r;
	logic [15:0]           cp_age_r;
	logic                  blocked;
	logic                  pc_clash;
	logic                  br_go;
	logic                  taken3;
	logic                  flush_now;
	logic                  cp_start;

	// ==========================================================
	// issue decision
	assign blocked  = cp_bus.busy || multi_left_r != 4'h0 || flush_cnt_r != 5'h00;
	assign pc_clash = (slot0.src_pc && is_branch(slot1))
		|| (is_branch(slot0) && slot1.src_pc);
	assign issue0   = slot0.valid && !blocked && !hazard(slot0);
	// a flag setter pairs with a branch, flags reach the branch in stage three
	assign issue1   = issue0 && slot1.valid && !hazard(slot1) && !pc_clash
		&& !(is_branch(slot0) && is_branch(slot1))
		&& exec_cycles(slot0) == 4'h1 && exec_cycles(slot1) == 4'h1
		&& slot0.kind != bci_pkg::BCI_K_CP && slot1.kind != bci_pkg::BCI_K_CP
		&& !(slot0.sets_flags && slot1.cond && !is_branch(slot1));
	assign flush_active = flush_cnt_r != 5'h00;

	assign br_src = is_branch(slot0) ? slot0 : slot1;
	assign br_go  = (issue0 && is_branch(slot0)) || (issue1 && is_branch(slot1));

	always_comb begin
		tok_new            = '0;
		tok_new.valid      = br_go;
		tok_new.link       = br_src.kind == bci_pkg::BCI_K_LINK_BR;
		tok_new.cond       = br_src.cond;
		tok_new.pred_taken = br_src.pred_taken;
		tok_new.target     = br_src.target_pc;
		tok_new.ret        = br_src.next_pc;
	end

	// ==========================================================
	// branch token pipe, condition in stage three, resolution in stage four
	assign taken3    = !st_r[3].cond || cond_pass_ex3;
	assign flush_now = st_r[3].valid && taken3 != st_r[3].pred_taken;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			st_r[1] <= '0;
			st_r[2] <= '0;
			st_r[3] <= '0;
		end else begin
			st_r[1] <= flush_now ? '0 : tok_new;
			st_r[2] <= flush_now ? '0 : st_r[1];
			st_r[3] <= flush_now ? '0 : st_r[2];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			st_r[4] <= '0;
		else begin
			st_r[4]        <= st_r[3];
			st_r[4].misp   <= st_r[3].valid && taken3 != st_r[3].pred_taken;
			st_r[4].target <= taken3 ? st_r[3].target : st_r[3].ret;
		end
	end

	assign br_resolve    = st_r[4].valid;
	assign br_mispredict = st_r[4].valid && st_r[4].misp;
	assign br_new_pc     = st_r[4].target;
	// return address written in stage three, dropped if the condition failed
	assign lr_wr_en      = st_r[3].valid && st_r[3].link && taken3;
	assign lr_wr_data    = st_r[3].ret;

	always_ff @(posedge sys_clk) begin
		if (reset)
			flush_cnt_r <= 5'h00;
		else if (flush_now)
			flush_cnt_r <= 5'(bci_pkg::MISPREDICT_CYCLES);
		else if (flush_cnt_r != 5'h00)
			flush_cnt_r <= flush_cnt_r - 5'h01;
	end

	// ==========================================================
	// multi-cycle occupancy
	always_ff @(posedge sys_clk) begin
		if (reset)
			multi_left_r <= 4'h0;
		else if (issue0 && exec_cycles(slot0) > 4'h1)
			multi_left_r <= exec_cycles(slot0) - 4'h1;
		else if (multi_left_r != 4'h0)
			multi_left_r <= multi_left_r - 4'h1;
	end

	// ==========================================================
	// serialized coprocessor transfers
	assign cp_start      = issue0 && nonpipe(slot0);
	assign cp_bus.start  = cp_start;
	assign cp_bus.alt    = slot0.cp_num == bci_pkg::CP_NUM_SYS && slot0.cp_op1 == 3'h0
		&& slot0.cp_crn == 4'h7 && slot0.cp_write
		&& bci_pkg::dc_line_op(slot0.cp_crm, slot0.cp_op2)
		&& !aux_ctrl_word[bci_pkg::AUX_DC_TIMING_BIT];
	assign cp_bus.ack    = cp_ack;
	assign cp_busy       = cp_bus.busy;
	assign cp_done       = cp_bus.done;

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cp_req        <= 1'b0;
			cp_unit       <= bci_pkg::BCI_U_NONE;
			cp_alt_timing <= 1'b0;
		end else begin
			cp_req <= cp_start;
			if (cp_start) begin
				cp_unit       <= bci_pkg::cp_unit(slot0);
				cp_alt_timing <= cp_bus.alt;
			end
		end
	end

	bci_cp_seq #(
		.MIN_CYCLES     (CP_MIN),
		.ALT_MIN_CYCLES (CP_ALT_MIN)
	) u_seq (
		.sys_clk (sys_clk),
		.reset   (reset),
		.cp      (cp_bus)
	);

	// ==========================================================
	// checks
	always_ff @(posedge sys_clk) begin
		if (reset || cp_start)
			cp_age_r <= 16'h0000;
		else if (cp_age_r != 16'hFFFF)
			cp_age_r <= cp_age_r + 16'h0001;
	end

	a_cp_min_time: assert property (@(posedge sys_clk) disable iff (reset)
		cp_done |-> cp_age_r >= 16'(CP_MIN)) else $error("coprocessor done too soon");
	a_cp_alt_time: assert property (@(posedge sys_clk) disable iff (reset)
		(cp_done && cp_alt_timing) |-> cp_age_r >= 16'(CP_ALT_MIN))
		else $error("alternative timing too short");
	a_cp_serial: assert property (@(posedge sys_clk) disable iff (reset)
		cp_busy |-> !issue0) else $error("issue during serialized transfer");
	a_dbg_nonpipe: assert property (@(posedge sys_clk) disable iff (reset)
		(issue0 && slot0.kind == bci_pkg::BCI_K_CP && slot0.cp_num == bci_pkg::CP_NUM_DEBUG
		&& slot0.cp_op1 == 3'h0) |=> cp_busy && cp_req) else $error("debug transfer pipelined");
	a_pc_dual: assert property (@(posedge sys_clk) disable iff (reset)
		issue1 |-> !((slot0.src_pc && (slot1.dst_pc || slot1.kind == bci_pkg::BCI_K_COND_BR
		|| slot1.kind == bci_pkg::BCI_K_LINK_BR || slot1.kind == bci_pkg::BCI_K_EXCH_BR))
		|| (slot1.src_pc && (slot0.dst_pc || slot0.kind == bci_pkg::BCI_K_COND_BR
		|| slot0.kind == bci_pkg::BCI_K_LINK_BR || slot0.kind == bci_pkg::BCI_K_EXCH_BR))))
		else $error("pc reader paired with pc writer");
	a_src_hazard: assert property (@(posedge sys_clk) disable iff (reset)
		(slot0.valid && slot0.src_reg != bci_pkg::PC_REG && slot0.src_avail > slot0.src_need
		&& slot0.kind != bci_pkg::BCI_K_EXCH_BR) |-> !issue0) else $error("operand hazard ignored");
	a_resolve_e4: assert property (@(posedge sys_clk) disable iff (reset)
		br_resolve |-> $past(br_go, 4)) else $error("resolution not in stage four");
	a_link_stage: assert property (@(posedge sys_clk) disable iff (reset)
		lr_wr_en |-> $past(br_go, 3)) else $error("link write not in stage three");
	a_load_extra: assert property (@(posedge sys_clk) disable iff (reset)
		(issue0 && slot0.kind == bci_pkg::BCI_K_LOAD && slot0.dst_pc)
		|=> multi_left_r == $past(slot0.base_cycles)) else $error("load to pc lacks extra cycle");
	a_flag_pair: assert property (@(posedge sys_clk) disable iff (reset)
		(issue0 && slot0.sets_flags && slot1.valid && slot1.cond && !is_branch(slot1))
		|-> !issue1) else $error("conditional paired with flag setter");
	a_flush_len: assert property (@(posedge sys_clk) disable iff (reset)
		br_mispredict |-> flush_cnt_r == 5'h0D ##12 flush_cnt_r == 5'h01 ##1 flush_cnt_r == 5'h00)
		else $error("flush length wrong");
endmodule

// ==== common/bci_pkg.sv ====
package bci_pkg;

	// ==========================================================
	// timing and field constants
	localparam int         CP_MIN_CYCLES     = 60;
	localparam int         CP_ALT_MIN_CYCLES = 120;
	localparam int         MISPREDICT_CYCLES = 13;
	localparam int         AUX_DC_TIMING_BIT = 20;
	localparam logic [3:0] PC_REG            = 4'hF;
	localparam logic [3:0] CP_NUM_DEBUG      = 4'hE;
	localparam logic [3:0] CP_NUM_SYS        = 4'hF;
	localparam logic [2:0] STG_EX_TWO        = 3'h2;

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		BCI_K_OTHER, BCI_K_COND_BR, BCI_K_LINK_BR, BCI_K_EXCH_BR, BCI_K_DP, BCI_K_LOAD, BCI_K_CP
	} bci_kind_e;

	typedef enum logic [3:0] {
		BCI_U_NONE, BCI_U_CTRL, BCI_U_MMU, BCI_U_FAULT, BCI_U_CACHE, BCI_U_TLB, BCI_U_BARRIER,
		BCI_U_L2, BCI_U_PRELOAD, BCI_U_CONTEXT, BCI_U_ARRAY, BCI_U_DEBUG
	} bci_unit_e;

	typedef struct packed {
		logic        valid;
		bci_kind_e   kind;
		logic        dst_pc;
		logic        src_pc;
		logic        sets_flags;
		logic        cond;
		logic [3:0]  src_reg;
		logic [2:0]  src_need;
		logic [2:0]  src_avail;
		logic [3:0]  base_cycles;
		logic [31:0] target_pc;
		logic [31:0] next_pc;
		logic        pred_taken;
		logic [3:0]  cp_num;
		logic [2:0]  cp_op1;
		logic [3:0]  cp_crn;
		logic [3:0]  cp_crm;
		logic [2:0]  cp_op2;
		logic        cp_write;
	} bci_instr_s;

	typedef struct packed {
		logic        valid;
		logic        link;
		logic        cond;
		logic        pred_taken;
		logic        misp;
		logic [31:0] target;
		logic [31:0] ret;
	} bci_tok_s;

	// ==========================================================
	// coprocessor decode
	function automatic logic dc_line_op(input logic [3:0] crm, input logic [2:0] op2);
		return ((crm == 4'h6 || crm == 4'hA || crm == 4'hE) && (op2 == 3'h1 || op2 == 3'h2))
			|| (crm == 4'hB && op2 == 3'h1);
	endfunction

	function automatic bci_unit_e cp_unit(input bci_instr_s i);
		bci_unit_e u;
		u = BCI_U_NONE;
		if (i.cp_num == CP_NUM_DEBUG) begin
			if (i.cp_op1 == 3'h0)
				u = BCI_U_DEBUG;
		end else if (i.cp_num == CP_NUM_SYS) begin
			if (i.cp_crn == 4'hF)
				u = BCI_U_ARRAY;
			else if (i.cp_op1 == 3'h1) begin
				if (i.cp_write && i.cp_crn == 4'h9 && i.cp_crm == 4'h0
					&& (i.cp_op2 == 3'h0 || i.cp_op2 == 3'h2))
					u = BCI_U_L2;
			end else if (i.cp_op1 == 3'h0) begin
				case (i.cp_crn)
					4'h1: if (i.cp_write && i.cp_crm == 4'h0 && i.cp_op2 <= 3'h1) u = BCI_U_CTRL;
					4'h2: if (i.cp_write && i.cp_crm == 4'h0 && i.cp_op2 <= 3'h2) u = BCI_U_MMU;
					4'h3: if (i.cp_write && i.cp_crm == 4'h0 && i.cp_op2 == 3'h0) u = BCI_U_MMU;
					4'h5: if (i.cp_crm <= 4'h1 && i.cp_op2 <= 3'h1) u = BCI_U_FAULT;
					4'h6: if (i.cp_crm == 4'h0 && i.cp_op2 <= 3'h1) u = BCI_U_FAULT;
					4'h7: if (i.cp_write) begin
						if (i.cp_crm == 4'h8)
							u = BCI_U_MMU;
						else if (i.cp_crm == 4'hA && (i.cp_op2 == 3'h4 || i.cp_op2 == 3'h5))
							u = BCI_U_BARRIER;
						else if (dc_line_op(i.cp_crm, i.cp_op2)
							|| (i.cp_crm == 4'h5 && i.cp_op2 == 3'h1))
							u = BCI_U_CACHE;
					end
					4'h8: if (i.cp_write && i.cp_crm >= 4'h5 && i.cp_crm <= 4'h7
						&& i.cp_op2 <= 3'h2) u = BCI_U_TLB;
					4'hA: if (i.cp_write && i.cp_op2 <= 3'h1)
						u = (i.cp_crm <= 4'h1) ? BCI_U_TLB
							: ((i.cp_crm == 4'h2) ? BCI_U_MMU : BCI_U_NONE);
					4'hB: if (i.cp_write && ((i.cp_op2 == 3'h0 && (i.cp_crm == 4'h1
						|| i.cp_crm == 4'h2 || i.cp_crm == 4'h4 || i.cp_crm == 4'hF))
						|| (i.cp_crm == 4'h3 && i.cp_op2 <= 3'h2))) u = BCI_U_PRELOAD;
					4'hD: if (i.cp_write && i.cp_crm == 4'h0 && i.cp_op2 == 3'h0) u = BCI_U_CONTEXT;
					default: u = BCI_U_NONE;
				endcase
			end
		end
		return u;
	endfunction

endpackage

// ==== common/bci_cp_if.sv ====
`timescale 1ns/1ps
// ==========================================================
// issue control to coprocessor sequencer
interface bci_cp_if;
	logic start;
	logic alt;
	logic ack;
	logic busy;
	logic done;
	modport ctl (output start, output alt, output ack, input busy, input done);
	modport seq (input start, input alt, input ack, output busy, output done);
endinterface

// ==== design/bci_cp_seq.sv ====
`timescale 1ns/1ps
module bci_cp_seq #(
	parameter int MIN_CYCLES     = bci_pkg::CP_MIN_CYCLES,
	parameter int ALT_MIN_CYCLES = bci_pkg::CP_ALT_MIN_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic reset,
	bci_cp_if.seq     cp
);
	logic        busy_r;
	logic        done_r;
	logic        alt_r;
	logic        ack_seen_r;
	logic [15:0] cnt_r;
	logic [15:0] min_cnt;
	logic        finish;

	assign cp.busy = busy_r;
	assign cp.done = done_r;
	// ==========================================================
	// completion: lower bound by count, real end by the unit's answer
	assign min_cnt = alt_r ? 16'(ALT_MIN_CYCLES) : 16'(MIN_CYCLES);
	assign finish  = busy_r && cnt_r >= min_cnt && (ack_seen_r || cp.ack);

	always_ff @(posedge sys_clk) begin
		if (reset)
			busy_r <= 1'b0;
		else if (cp.start)
			busy_r <= 1'b1;
		else if (finish)
			busy_r <= 1'b0;
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			done_r <= 1'b0;
		else
			done_r <= finish;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_r <= 16'h0000;
			alt_r <= 1'b0;
		end else if (cp.start) begin
			cnt_r <= 16'h0001;
			alt_r <= cp.alt;
		end else if (busy_r && cnt_r != 16'hFFFF)
			cnt_r <= cnt_r + 16'h0001;
	end

	// an early answer is held so the minimum time still applies
	always_ff @(posedge sys_clk) begin
		if (reset)
			ack_seen_r <= 1'b0;
		else if (cp.start)
			ack_seen_r <= 1'b0;
		else if (busy_r && cp.ack)
			ack_seen_r <= 1'b1;
	end

	a_seq_holds_busy: assert property (@(posedge sys_clk) disable iff (reset)
		(busy_r && cnt_r < min_cnt) |=> busy_r) else $error("sequencer ended early");
	a_seq_waits_ack: assert property (@(posedge sys_clk) disable iff (reset)
		(busy_r && !ack_seen_r && !cp.ack) |=> busy_r) else $error("ended without answer");
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
	// ==========================================================
	// setup: short coprocessor minimums keep the run brief
	localparam int CPM = 4;
	localparam int CPA = 8;
	typedef struct packed {
		logic [3:0]         num;
		logic [2:0]         op1;
		logic [3:0]         crn;
		logic [3:0]         crm;
		logic [2:0]         op2;
		logic               wr;
		logic               aux;
		bci_pkg::bci_unit_e unit;
		logic               alt;
		logic               ser;
	} bci_tb_cp_s;
	logic                sys_clk = 1'b0;
	logic                reset = 1'b1;
	bci_pkg::bci_instr_s slot0 = '0;
	bci_pkg::bci_instr_s slot1 = '0;
	logic                cond_pass_ex3 = 1'b1;
	logic [31:0]         aux_ctrl_word = 32'h0;
	logic                cp_ack = 1'b0;
	logic                issue0, issue1, br_resolve, br_mispredict, lr_wr_en;
	logic [31:0]         br_new_pc, lr_wr_data;
	logic                cp_req, cp_alt_timing, cp_busy, cp_done, flush_active;
	bci_pkg::bci_unit_e  cp_unit;
	int                  fails = 0;
	int                  checks = 0;
	int                  cyc = 0;
	bci_tb_cp_s cpt [20] = '{
		'{4'hE, 3'h0, 4'h3, 4'h7, 3'h5, 1'b0, 1'b1, bci_pkg::BCI_U_DEBUG, 1'b0, 1'b1},
		'{4'hE, 3'h1, 4'h0, 4'h0, 3'h0, 1'b1, 1'b1, bci_pkg::BCI_U_NONE, 1'b0, 1'b0},
		'{4'hF, 3'h0, 4'h1, 4'h0, 3'h0, 1'b1, 1'b0, bci_pkg::BCI_U_CTRL, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h2, 4'h0, 3'h2, 1'b1, 1'b1, bci_pkg::BCI_U_MMU, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h3, 4'h0, 3'h0, 1'b1, 1'b1, bci_pkg::BCI_U_MMU, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h5, 4'h1, 3'h1, 1'b0, 1'b1, bci_pkg::BCI_U_FAULT, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h6, 4'h0, 3'h1, 1'b1, 1'b1, bci_pkg::BCI_U_FAULT, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'hA, 3'h4, 1'b1, 1'b1, bci_pkg::BCI_U_BARRIER, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'h8, 3'h6, 1'b1, 1'b1, bci_pkg::BCI_U_MMU, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'hE, 3'h2, 1'b1, 1'b0, bci_pkg::BCI_U_CACHE, 1'b1, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'hB, 3'h1, 1'b1, 1'b0, bci_pkg::BCI_U_CACHE, 1'b1, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'h5, 3'h1, 1'b1, 1'b0, bci_pkg::BCI_U_CACHE, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h8, 4'h6, 3'h2, 1'b1, 1'b1, bci_pkg::BCI_U_TLB, 1'b0, 1'b1},
		'{4'hF, 3'h1, 4'h9, 4'h0, 3'h2, 1'b1, 1'b1, bci_pkg::BCI_U_L2, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'hA, 4'h2, 3'h1, 1'b1, 1'b1, bci_pkg::BCI_U_MMU, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'hB, 4'h3, 3'h1, 1'b1, 1'b1, bci_pkg::BCI_U_PRELOAD, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'hD, 4'h0, 3'h0, 1'b1, 1'b1, bci_pkg::BCI_U_CONTEXT, 1'b0, 1'b1},
		'{4'hF, 3'h3, 4'hF, 4'h0, 3'h0, 1'b0, 1'b1, bci_pkg::BCI_U_ARRAY, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h7, 4'h6, 3'h1, 1'b1, 1'b1, bci_pkg::BCI_U_CACHE, 1'b0, 1'b1},
		'{4'hF, 3'h0, 4'h3, 4'h1, 3'h0, 1'b1, 1'b1, bci_pkg::BCI_U_NONE, 1'b0, 1'b0}
	};

	bci_issue_ctrl #(.CP_MIN(CPM), .CP_ALT_MIN(CPA)) bci_issue_ctrl_inst (
		.sys_clk(sys_clk), .reset(reset), .slot0(slot0), .slot1(slot1),
		.cond_pass_ex3(cond_pass_ex3), .aux_ctrl_word(aux_ctrl_word), .cp_ack(cp_ack),
		.issue0(issue0), .issue1(issue1), .br_resolve(br_resolve),
		.br_mispredict(br_mispredict), .br_new_pc(br_new_pc), .lr_wr_en(lr_wr_en),
		.lr_wr_data(lr_wr_data), .cp_req(cp_req), .cp_unit(cp_unit),
		.cp_alt_timing(cp_alt_timing), .cp_busy(cp_busy), .cp_done(cp_done),
		.flush_active(flush_active)
	);

	always #5 sys_clk = ~sys_clk;

	// ==========================================================
	// helpers: inputs change at the falling edge or 1ns after it
	task automatic test_done();
		if (fails == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// a hang must still reach the verdict
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			test_done();
		end
	end

	function automatic bci_pkg::bci_instr_s mk(input bci_pkg::bci_kind_e k);
		bci_pkg::bci_instr_s i;
		i = '0;
		i.valid = 1'b1;
		i.kind = k;
		i.base_cycles = 4'h1;
		i.pred_taken = 1'b1;
		return i;
	endfunction

	task automatic offer(input bci_pkg::bci_instr_s a, input bci_pkg::bci_instr_s b,
		input logic e0, input logic e1);
		@(negedge sys_clk);
		slot0 = a;
		slot1 = b;
		#1;
		`CHK("issue0", e0, issue0)
		`CHK("issue1", e1, issue1)
	endtask

	task automatic adv(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			slot0 = '0;
			slot1 = '0;
		end
		#1;
	endtask

	task automatic flush_check();
		int n;
		n = 0;
		slot0 = mk(bci_pkg::BCI_K_OTHER);
		#1;
		while (flush_active === 1'b1 && n < 40) begin
			`CHK("flush_issue0", 1'b0, issue0)
			n++;
			@(negedge sys_clk);
			#1;
		end
		`CHK("flush_len", bci_pkg::MISPREDICT_CYCLES, n)
		`CHK("flush_end_issue0", 1'b1, issue0)
		adv(1);
	endtask

	task automatic branch(input bci_pkg::bci_kind_e k, input logic cnd, input logic prd,
		input logic pass);
		bci_pkg::bci_instr_s b;
		logic                tk;
		logic                lnk;
		b = mk(k);
		b.dst_pc = (k == bci_pkg::BCI_K_DP);
		b.cond = cnd;
		b.pred_taken = prd;
		b.target_pc = $urandom;
		b.next_pc = $urandom;
		tk = !cnd || pass;
		lnk = (k == bci_pkg::BCI_K_LINK_BR);
		cond_pass_ex3 = pass;
		offer(b, '0, 1'b1, 1'b0);
		adv(2);
		`CHK("lr_early", 1'b0, lr_wr_en)
		adv(1);
		`CHK("lr_wr_en", tk && lnk, lr_wr_en)
		if (tk && lnk) `CHK("lr_wr_data", b.next_pc, lr_wr_data)
		adv(1);
		`CHK("br_resolve", 1'b1, br_resolve)
		`CHK("br_new_pc", tk ? b.target_pc : b.next_pc, br_new_pc)
		`CHK("br_mispredict", tk != prd, br_mispredict)
		if (tk != prd)
			flush_check();
		else begin
			adv(1);
			`CHK("br_pulse", 1'b0, br_resolve)
		end
		cond_pass_ex3 = 1'b1;
	endtask

	task automatic cp_run(input bci_tb_cp_s e);
		bci_pkg::bci_instr_s c;
		int                  k, n, ex;
		c = mk(bci_pkg::BCI_K_CP);
		c.cp_num = e.num;
		c.cp_op1 = e.op1;
		c.cp_crn = e.crn;
		c.cp_crm = e.crm;
		c.cp_op2 = e.op2;
		c.cp_write = e.wr;
		aux_ctrl_word = $urandom;
		aux_ctrl_word[bci_pkg::AUX_DC_TIMING_BIT] = e.aux;
		k = 1 + $urandom_range(11);
		ex = (e.alt ? CPA : CPM) + 1;
		if (k + 1 > ex)
			ex = k + 1;
		offer(c, '0, 1'b1, 1'b0);
		if (!e.ser) begin
			adv(1);
			`CHK("cp_req_pipelined", 1'b0, cp_req)
			`CHK("cp_busy_pipelined", 1'b0, cp_busy)
		end else begin
			@(negedge sys_clk);
			n = 1;
			slot0 = mk(bci_pkg::BCI_K_OTHER);
			slot1 = '0;
			cp_ack = (n >= k);
			#1;
			`CHK("cp_req", 1'b1, cp_req)
			`CHK("cp_unit", e.unit, cp_unit)
			`CHK("cp_alt_timing", e.alt, cp_alt_timing)
			while (cp_done !== 1'b1 && n < 400) begin
				`CHK("cp_busy", 1'b1, cp_busy)
				`CHK("cp_hold_issue0", 1'b0, issue0)
				@(negedge sys_clk);
				n++;
				cp_ack = (n >= k);
				#1;
			end
			`CHK("cp_done_cycle", ex, n)
			`CHK("cp_busy_end", 1'b0, cp_busy)
			`CHK("cp_next_issue0", 1'b1, issue0)
			cp_ack = 1'b0;
			adv(1);
		end
	endtask

	// ==========================================================
	// main sequence
	initial begin
		bci_pkg::bci_instr_s p, ld, dp, ex, rd, fs, cb;
		bci_pkg::bci_kind_e  ks [3];
		void'($urandom(32'h6a32));
		ks = '{bci_pkg::BCI_K_COND_BR, bci_pkg::BCI_K_LINK_BR, bci_pkg::BCI_K_DP};
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk);
		`CHK("rst_cp_busy", 1'b0, cp_busy)
		`CHK("rst_cp_unit", bci_pkg::BCI_U_NONE, cp_unit)
		`CHK("rst_flush", 1'b0, flush_active)
		reset = 1'b0;
		p = mk(bci_pkg::BCI_K_OTHER);
		ld = mk(bci_pkg::BCI_K_LOAD);
		ld.dst_pc = 1'b1;
		offer(ld, '0, 1'b1, 1'b0);
		offer(p, '0, 1'b0, 1'b0);
		offer(p, '0, 1'b1, 1'b0);
		ld.dst_pc = 1'b0;
		offer(ld, '0, 1'b1, 1'b0);
		offer(p, '0, 1'b1, 1'b0);
		dp = mk(bci_pkg::BCI_K_DP);
		dp.dst_pc = 1'b1;
		dp.src_reg = 4'h3;
		dp.src_need = 3'h1;
		dp.src_avail = 3'h2;
		offer(dp, '0, 1'b0, 1'b0);
		dp.src_avail = 3'h0;
		offer(dp, '0, 1'b1, 1'b0);
		offer(p, '0, 1'b1, 1'b0);
		dp.src_reg = bci_pkg::PC_REG;
		dp.src_avail = 3'h2;
		offer(dp, '0, 1'b1, 1'b0);
		ex = mk(bci_pkg::BCI_K_EXCH_BR);
		ex.src_reg = 4'h5;
		ex.src_avail = 3'h3;
		offer(ex, '0, 1'b0, 1'b0);
		ex.src_avail = bci_pkg::STG_EX_TWO;
		offer(ex, '0, 1'b1, 1'b0);
		rd = mk(bci_pkg::BCI_K_OTHER);
		rd.src_pc = 1'b1;
		offer(dp, rd, 1'b1, 1'b0);
		offer(p, rd, 1'b1, 1'b1);
		fs = mk(bci_pkg::BCI_K_OTHER);
		fs.sets_flags = 1'b1;
		cb = mk(bci_pkg::BCI_K_COND_BR);
		cb.cond = 1'b1;
		offer(fs, cb, 1'b1, 1'b1);
		p.cond = 1'b1;
		offer(fs, p, 1'b1, 1'b0);
		adv(6);
		branch(bci_pkg::BCI_K_LINK_BR, 1'b1, 1'b1, 1'b0);
		branch(bci_pkg::BCI_K_COND_BR, 1'b1, 1'b0, 1'b0);
		repeat (8)
			branch(ks[$urandom_range(2)], $urandom_range(1), $urandom_range(1), $urandom_range(1));
		foreach (cpt[i])
			cp_run(cpt[i]);
		cp_run(cpt[$urandom_range(19)]);
		test_done();
	end
endmodule
